// file: design/chd_consts.vh
/*
 constants of the capability header decoder: register offsets, field
 positions, reset values and the required/useful class of each extension flag.
 assumes inclusion by bare name from the design files.
*/
`ifndef CHD_CONSTS_VH
`define CHD_CONSTS_VH

// register byte offsets
`define CHD_OFF_CTRL 12'h000
`define CHD_OFF_SUPPORT 12'h004
`define CHD_OFF_CAP 12'h008
`define CHD_OFF_COMP 12'h00C
`define CHD_OFF_ERR 12'h010
`define CHD_OFF_SEGCNT 12'h014

// reset values
`define CHD_RST_CTRL 1'h1
`define CHD_RST_SUPPORT 10'h3FF
`define CHD_RST_BASE 1'h1

// capability word fields
`define CHD_CAP_EXT_BIT 15
`define CHD_CAP_DC_BIT 0
`define CHD_CAP_MCT_BIT 7
`define CHD_NUM_FLAGS 10
`define CHD_REQ_MASK 10'h273
`define CHD_USE_MASK 10'h18C

// component word fields
`define CHD_COMP_CNT_MSB 13
`define CHD_COMP_VOFF_BIT 14
`define CHD_COMP_HOFF_BIT 15

// status register field positions
`define CHD_CAPST_EXT_BIT 16
`define CHD_CAPST_BASE_BIT 17
`define CHD_ERR_FATAL_BIT 0
`define CHD_ERR_DEGR_BIT 1
`define CHD_ERR_RSVCAP_BIT 2
`define CHD_ERR_ZCNT_BIT 3
`define CHD_ERR_WIDTH 4

`endif

// file: design/chd_cap_map.v
/*
 combinational map of a capability word onto the ten extension flags.
 assumes the caller registers the result and only samples it on a strobe.
*/
`timescale 1ns/10ps
`default_nettype none

`include "chd_consts.vh"

module chd_cap_map #(
    parameter NF = `CHD_NUM_FLAGS
) (
    input wire [15:0] cap_word,
    output wire [NF-1:0] cap_flags,
    output wire ext_present,
    output wire base_only,
    output wire rsv_cap
);
    // bits 10..14 are don't-care and never reach a flag
    wire ext;
    assign ext = cap_word[`CHD_CAP_EXT_BIT];
    assign ext_present = ext;
    assign base_only = (cap_word == 16'h0000);
    // bits below the indicator with the indicator clear are a reserved form
    assign rsv_cap = ~ext & (cap_word != 16'h0000);

    genvar i;
    generate
        for (i = 0; i < NF; i = i + 1) begin : g_flag
            if (i == `CHD_CAP_DC_BIT) begin : g_dc
                assign cap_flags[i] = ext & ~cap_word[`CHD_CAP_MCT_BIT] & cap_word[i];
            end else if (i == `CHD_CAP_MCT_BIT) begin : g_mct
                assign cap_flags[i] = ext & cap_word[i] & ~cap_word[`CHD_CAP_DC_BIT];
            end else begin : g_plain
                assign cap_flags[i] = ext & cap_word[i];
            end
        end
    endgenerate
endmodule // chd_cap_map

`default_nettype wire

// file: design/chd_decoder.v
/*
 capability header decoder: takes the capability and component words of the
 image_size_segment from the parser, registers the decoded flags, checks them
 against the supported set, and exposes everything over an APB slave.
 assumes parser strobes are on pclk and last one cycle; APB answers with
 no wait states.
*/
`timescale 1ns/10ps
`default_nettype none

`include "chd_consts.vh"

module chd_decoder #(
    parameter NF = `CHD_NUM_FLAGS,
    parameter CW = 14,
    parameter SEGW = 16
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output wire [31:0] prdata,
    output wire pslverr,
    input wire cap_valid,
    input wire [15:0] cap_word,
    input wire comp_valid,
    input wire [15:0] comp_word,
    input wire ext_seg_valid,
    output wire ext_seg_ready,
    output wire [NF-1:0] cap_flags,
    output wire [NF-1:0] req_flags,
    output wire [NF-1:0] use_flags,
    output wire ext_present,
    output wire base_only,
    output wire [CW-1:0] comp_count,
    output wire vert_offset,
    output wire horiz_offset,
    output wire decode_fatal,
    output wire decode_degraded,
    output wire reserved_err,
    output wire cap_done,
    output wire comp_done
);
    localparam [NF-1:0] REQ_MASK = `CHD_REQ_MASK;
    localparam [NF-1:0] USE_MASK = `CHD_USE_MASK;

    // decoded state
    reg [NF-1:0] cap_flags_ff;
    reg ext_present_ff;
    reg base_only_ff;
    reg [CW-1:0] comp_count_ff;
    reg vert_offset_ff;
    reg horiz_offset_ff;
    reg decode_fatal_ff;
    reg decode_degraded_ff;
    reg cap_done_ff;
    reg comp_done_ff;

    // software state
    reg enable_ff;
    reg [NF-1:0] support_ff;
    reg [`CHD_ERR_WIDTH-1:0] err_ff;
    reg [SEGW-1:0] seg_count_ff;

    // bus answer
    reg [31:0] prdata_ff;
    reg pslverr_ff;

    // next values
    reg [`CHD_ERR_WIDTH-1:0] nxt_err;
    reg [31:0] nxt_rdata;
    reg nxt_slverr;

    wire [NF-1:0] map_flags;
    wire map_ext;
    wire map_base;
    wire map_rsv;

    chd_cap_map #(
        .NF(NF)
    ) u_map (
        .cap_word(cap_word),
        .cap_flags(map_flags),
        .ext_present(map_ext),
        .base_only(map_base),
        .rsv_cap(map_rsv)
    );

    // capability and component strobes are only honoured while decoding is enabled
    wire cap_take;
    wire comp_take;
    assign cap_take = cap_valid & enable_ff;
    assign comp_take = comp_valid & enable_ff;

    // class check against what this decoder instance can do
    wire [NF-1:0] missing;
    wire map_fatal;
    wire map_degr;
    assign missing = map_flags & ~support_ff;
    assign map_fatal = |(missing & REQ_MASK);
    assign map_degr = |(missing & USE_MASK);

    // count field is taken as unsigned; bits 14 and 15 never leak into it
    wire [CW-1:0] cnt_field;
    wire cnt_zero;
    assign cnt_field = comp_word[`CHD_COMP_CNT_MSB:0];
    assign cnt_zero = (cnt_field == {CW{1'b0}});

    // apb decode
    wire apb_setup;
    wire apb_wr;
    wire apb_rd_setup;
    assign apb_setup = psel & ~penable;
    assign apb_wr = psel & penable & pwrite;
    assign apb_rd_setup = apb_setup & ~pwrite;

    wire mapped;
    assign mapped = (paddr == `CHD_OFF_CTRL) | (paddr == `CHD_OFF_SUPPORT) |
                    (paddr == `CHD_OFF_CAP) | (paddr == `CHD_OFF_COMP) |
                    (paddr == `CHD_OFF_ERR) | (paddr == `CHD_OFF_SEGCNT);

    // write strobes, one per writable register
    wire wr_ctrl;
    wire wr_support;
    wire wr_err;
    assign wr_ctrl = apb_wr & (paddr == `CHD_OFF_CTRL);
    assign wr_support = apb_wr & (paddr == `CHD_OFF_SUPPORT);
    assign wr_err = apb_wr & (paddr == `CHD_OFF_ERR);

    // capability word decode
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_flags_ff <= {NF{1'b0}};
            ext_present_ff <= 1'b0;
            base_only_ff <= `CHD_RST_BASE;
            decode_fatal_ff <= 1'b0;
            decode_degraded_ff <= 1'b0;
            cap_done_ff <= 1'b0;
        end else begin
            cap_done_ff <= cap_take;
            if (cap_take) begin
                cap_flags_ff <= map_flags;
                ext_present_ff <= map_ext;
                base_only_ff <= map_base;
                decode_fatal_ff <= map_fatal;
                decode_degraded_ff <= map_degr;
            end
        end
    end

    // component word decode
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comp_count_ff <= {CW{1'b0}};
            vert_offset_ff <= 1'b0;
            horiz_offset_ff <= 1'b0;
            comp_done_ff <= 1'b0;
        end else begin
            comp_done_ff <= comp_take;
            if (comp_take) begin
                comp_count_ff <= cnt_field;
                vert_offset_ff <= comp_word[`CHD_COMP_VOFF_BIT];
                horiz_offset_ff <= comp_word[`CHD_COMP_HOFF_BIT];
            end
        end
    end

    // sticky error bits: a write of one clears, a new event in the same
    // cycle wins so no event is lost
    always @* begin
        nxt_err = err_ff;
        if (wr_err) begin
            nxt_err = err_ff & ~pwdata[`CHD_ERR_WIDTH-1:0];
        end
        if (cap_take) begin
            if (map_fatal) begin
                nxt_err[`CHD_ERR_FATAL_BIT] = 1'b1;
            end
            if (map_degr) begin
                nxt_err[`CHD_ERR_DEGR_BIT] = 1'b1;
            end
            if (map_rsv) begin
                nxt_err[`CHD_ERR_RSVCAP_BIT] = 1'b1;
            end
        end
        if (comp_take && cnt_zero) begin
            nxt_err[`CHD_ERR_ZCNT_BIT] = 1'b1;
        end
    end

    // next values of the software registers
    reg nxt_enable;
    reg [NF-1:0] nxt_support;
    reg [SEGW-1:0] nxt_seg_count;
    wire seg_full;
    assign seg_full = (seg_count_ff == {SEGW{1'b1}});

    // the segment count ignores enable: a segment seen while decoding is
    // paused is still retained and must still be counted
    always @* begin
        nxt_enable = enable_ff;
        nxt_support = support_ff;
        nxt_seg_count = seg_count_ff;
        if (wr_ctrl) begin
            nxt_enable = pwdata[0];
        end
        if (wr_support) begin
            nxt_support = pwdata[NF-1:0];
        end
        // saturates rather than wrapping so software never sees a
        // small count after a flood of segments
        if (ext_seg_valid && !seg_full) begin
            nxt_seg_count = seg_count_ff + {{(SEGW-1){1'b0}}, 1'b1};
        end
    end

    // control registers and the retained segment count
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_ff <= `CHD_RST_CTRL;
            support_ff <= `CHD_RST_SUPPORT;
            err_ff <= {`CHD_ERR_WIDTH{1'b0}};
            seg_count_ff <= {SEGW{1'b0}};
        end else begin
            err_ff <= nxt_err;
            enable_ff <= nxt_enable;
            support_ff <= nxt_support;
            seg_count_ff <= nxt_seg_count;
        end
    end

    // read mux, sampled in the setup cycle so the data stands in the access
    // phase from a flip-flop; all unused bits read as zero
    always @* begin
        nxt_rdata = 32'h00000000;
        nxt_slverr = 1'b0;
        case (paddr)
            `CHD_OFF_CTRL: begin
                nxt_rdata[0] = enable_ff;
            end
            `CHD_OFF_SUPPORT: begin
                nxt_rdata[NF-1:0] = support_ff;
            end
            `CHD_OFF_CAP: begin
                nxt_rdata[NF-1:0] = cap_flags_ff;
                nxt_rdata[`CHD_CAPST_EXT_BIT] = ext_present_ff;
                nxt_rdata[`CHD_CAPST_BASE_BIT] = base_only_ff;
            end
            `CHD_OFF_COMP: begin
                // unsigned count, zero extended
                nxt_rdata[CW-1:0] = comp_count_ff;
                nxt_rdata[`CHD_COMP_VOFF_BIT] = vert_offset_ff;
                nxt_rdata[`CHD_COMP_HOFF_BIT] = horiz_offset_ff;
            end
            `CHD_OFF_ERR: begin
                nxt_rdata[`CHD_ERR_WIDTH-1:0] = err_ff;
            end
            `CHD_OFF_SEGCNT: begin
                nxt_rdata[SEGW-1:0] = seg_count_ff;
            end
            default: begin
                nxt_rdata = 32'h00000000;
            end
        endcase
        if (!mapped) begin
            nxt_slverr = 1'b1;
        end
    end

    // the answer is captured once per transfer; psel low clears the error
    // so a stale pslverr never meets a setup cycle that follows an idle cycle; back to back it stays until the new capture
    reg [31:0] nxt_prdata;
    reg nxt_pslverr;

    always @* begin
        nxt_prdata = prdata_ff;
        nxt_pslverr = pslverr_ff;
        if (apb_setup) begin
            nxt_prdata = apb_rd_setup ? nxt_rdata : 32'h00000000;
            nxt_pslverr = nxt_slverr;
        end else if (!psel) begin
            nxt_pslverr = 1'b0;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h00000000;
            pslverr_ff <= 1'b0;
        end else begin
            prdata_ff <= nxt_prdata;
            pslverr_ff <= nxt_pslverr;
        end
    end

    // zero wait states keep the parser side free of bus stalls
    assign pready = 1'b1;
    assign prdata = prdata_ff;
    assign pslverr = pslverr_ff;

    // segments are never refused, so none can be dropped
    assign ext_seg_ready = 1'b1;

    assign cap_flags = cap_flags_ff;
    assign req_flags = cap_flags_ff & REQ_MASK;
    assign use_flags = cap_flags_ff & USE_MASK;
    assign ext_present = ext_present_ff;
    assign base_only = base_only_ff;
    assign comp_count = comp_count_ff;
    assign vert_offset = vert_offset_ff;
    assign horiz_offset = horiz_offset_ff;
    assign decode_fatal = decode_fatal_ff;
    assign decode_degraded = decode_degraded_ff;
    assign reserved_err = |err_ff[`CHD_ERR_ZCNT_BIT:`CHD_ERR_RSVCAP_BIT];
    assign cap_done = cap_done_ff;
    assign comp_done = comp_done_ff;
endmodule // chd_decoder

`default_nettype wire

// file: tb/chd_decoder_asserts.sv
/* port assertions for the capability header decoder.
 assumes it is bound onto chd_decoder, one pclk domain. */
`timescale 1ns/10ps
`default_nettype none
module chd_decoder_asserts #(parameter NF = 10, parameter CW = 14) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cap_valid,
    input wire logic [15:0] cap_word,
    input wire logic comp_valid,
    input wire logic [15:0] comp_word,
    input wire logic [NF-1:0] cap_flags,
    input wire logic [NF-1:0] req_flags,
    input wire logic [NF-1:0] use_flags,
    input wire logic ext_present,
    input wire logic base_only,
    input wire logic [CW-1:0] comp_count,
    input wire logic vert_offset,
    input wire logic horiz_offset,
    input wire logic reserved_err,
    input wire logic cap_done,
    input wire logic comp_done
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_cause; (cap_done |-> $past(cap_valid)) and (comp_done |-> $past(comp_valid)); endproperty
    a_cause: assert property (p_cause) else $error("done without strobe");
    property p_ext; cap_done |-> ext_present == $past(cap_word[15]); endproperty
    a_ext: assert property (p_ext) else $error("ext_present wrong");
    property p_base; cap_done |-> base_only == ($past(cap_word) == 16'h0000); endproperty
    a_base: assert property (p_base) else $error("base_only wrong");
    property p_mid; cap_done |-> cap_flags[6:1] == ($past(cap_word[15]) ? $past(cap_word[6:1]) : 6'h00);
    endproperty
    a_mid: assert property (p_mid) else $error("flags 1 to 6 wrong");
    property p_dcmct; cap_done |-> cap_flags[0] == ($past(cap_word[15]) && $past(cap_word[0])
        && !$past(cap_word[7])) && cap_flags[7] == ($past(cap_word[15]) && $past(cap_word[7])
        && !$past(cap_word[0])); endproperty
    a_dcmct: assert property (p_dcmct) else $error("dc or mct flag wrong");
    property p_class; req_flags == (cap_flags & 10'h273) && use_flags == (cap_flags & 10'h18C);
    endproperty
    a_class: assert property (p_class) else $error("flag class wrong");
    property p_hold; !cap_done |-> $stable(cap_flags); endproperty
    a_hold: assert property (p_hold) else $error("flags moved without strobe");
    property p_comp; comp_done |-> comp_count == $past(comp_word[13:0]) &&
        vert_offset == $past(comp_word[14]) && horiz_offset == $past(comp_word[15]); endproperty
    a_comp: assert property (p_comp) else $error("component fields wrong");
    property p_zero; comp_done && comp_count == 14'h0000 |-> ##[0:1] reserved_err; endproperty
    a_zero: assert property (p_zero) else $error("zero count not flagged");
endmodule // chd_decoder_asserts
bind chd_decoder chd_decoder_asserts #(.NF(NF), .CW(CW)) i_chk (.pclk(pclk), .presetn(presetn),
    .cap_valid(cap_valid), .cap_word(cap_word), .comp_valid(comp_valid), .comp_word(comp_word),
    .cap_flags(cap_flags), .req_flags(req_flags), .use_flags(use_flags),
    .ext_present(ext_present), .base_only(base_only), .comp_count(comp_count),
    .vert_offset(vert_offset), .horiz_offset(horiz_offset), .reserved_err(reserved_err),
    .cap_done(cap_done), .comp_done(comp_done));
`default_nettype wire

// file: tb/chd_parser_model.sv
/* model of the upstream segment parser feeding header words.
 assumes tasks are called from the bench, one at a time. */
`timescale 1ns/10ps
`default_nettype none
module chd_parser_model (
    input wire logic pclk,
    output logic cap_valid,
    output logic [15:0] cap_word,
    output logic comp_valid,
    output logic [15:0] comp_word,
    output logic ext_seg_valid
);
    initial begin
        cap_valid = 1'b0;
        cap_word = 16'h5A5A;
        comp_valid = 1'b0;
        comp_word = 16'hA5A5;
        ext_seg_valid = 1'b0;
    end
    // words go out unsigned as given; x bits sent as set only where a test asks
    task automatic send_cap(input logic [15:0] w);
        @(posedge pclk);
        cap_valid <= 1'b1;
        cap_word <= w;
        @(posedge pclk);
        cap_valid <= 1'b0;
        cap_word <= ~w; // stale data must not be trusted
    endtask
    task automatic send_comp(input logic [15:0] w);
        @(posedge pclk);
        comp_valid <= 1'b1;
        comp_word <= w;
        @(posedge pclk);
        comp_valid <= 1'b0;
        comp_word <= ~w;
    endtask
    task automatic send_seg;
        @(posedge pclk);
        ext_seg_valid <= 1'b1;
        @(posedge pclk);
        ext_seg_valid <= 1'b0;
    endtask
endmodule // chd_parser_model
`default_nettype wire

// file: tb/capability_header_decoder_tb.sv
/* self-checking bench for chd_decoder with parser model.
 assumes zero-wait apb and one-cycle decode latency. */
`timescale 1ns/10ps
`default_nettype none
module capability_header_decoder_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_seg_ready, err;
    logic cap_valid, comp_valid, ext_seg_valid, ext_present, base_only, vert_offset;
    logic horiz_offset, decode_fatal, decode_degraded, reserved_err, cap_done, comp_done;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] cap_word, comp_word;
    logic [9:0] cap_flags, req_flags, use_flags, ef;
    logic [13:0] comp_count;
    int bad_count = 0;
    int comparisons = 0;
    chd_decoder i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .cap_valid(cap_valid), .cap_word(cap_word), .comp_valid(comp_valid),
        .comp_word(comp_word), .ext_seg_valid(ext_seg_valid), .ext_seg_ready(ext_seg_ready),
        .cap_flags(cap_flags), .req_flags(req_flags), .use_flags(use_flags),
        .ext_present(ext_present), .base_only(base_only), .comp_count(comp_count),
        .vert_offset(vert_offset), .horiz_offset(horiz_offset), .decode_fatal(decode_fatal),
        .decode_degraded(decode_degraded), .reserved_err(reserved_err), .cap_done(cap_done),
        .comp_done(comp_done));
    chd_parser_model i_par (.pclk(pclk), .cap_valid(cap_valid), .cap_word(cap_word),
        .comp_valid(comp_valid), .comp_word(comp_word), .ext_seg_valid(ext_seg_valid));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // waits for the answer; only the watchdog ends a hung transfer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // expected flags worked out from the bit table, not from the design
    function automatic logic [9:0] exp_flags(input logic [15:0] w);
        if (!w[15]) return 10'h000;
        return {w[9], w[8], w[7] & ~w[0], w[6:1], w[0] & ~w[7]};
    endfunction
    task t_regs;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h00000001);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h000003FF);
        apb(1'b0, 12'h018, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        $display("t_regs done");
    endtask
    task t_caps;
        logic [15:0] w [14] = '{16'h0000, 16'h8001, 16'h8080, 16'h8081, 16'h8002, 16'h8004,
            16'h8008, 16'h8010, 16'h8020, 16'h8040, 16'h8100, 16'h8200, 16'hFC00, 16'h0004};
        foreach (w[i]) begin
            i_par.send_cap(w[i]);
            #1;
            ef = exp_flags(w[i]);
            chk(cap_done, 1'b1);
            chk(cap_flags, ef);
            chk({req_flags, use_flags}, {ef & 10'h273, ef & 10'h18C});
            chk({ext_present, base_only}, {w[i][15], w[i] == 16'h0000});
        end
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h0);
        chk(reserved_err, 1'b1);
        apb(1'b1, 12'h010, 32'h0000000C);
        #1;
        chk(reserved_err, 1'b0);
        $display("t_caps done");
    endtask
    task t_support;
        apb(1'b1, 12'h004, 32'h0);
        i_par.send_cap(16'h8002);
        #1;
        chk({decode_fatal, decode_degraded}, 2'b10);
        i_par.send_cap(16'h8004);
        #1;
        chk({decode_fatal, decode_degraded}, 2'b01);
        apb(1'b1, 12'h004, 32'h000003FF);
        i_par.send_cap(16'h8206);
        #1;
        chk({decode_fatal, decode_degraded}, 2'b00);
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h00000003);
        $display("t_support done");
    endtask
    task t_comp;
        logic [15:0] w [4] = '{16'h0001, 16'h3FFF, 16'hC005, 16'h4000};
        foreach (w[i]) begin
            i_par.send_comp(w[i]);
            #1;
            chk({comp_done, horiz_offset, vert_offset, comp_count}, {1'b1, w[i]});
        end
        apb(1'b0, 12'h00C, 32'h0);
        chk(rd, 32'h00004000);
        chk(reserved_err, 1'b1);
        $display("t_comp done");
    endtask
    task t_seg;
        apb(1'b1, 12'h000, 32'h0);
        i_par.send_cap(16'h8002);
        #1;
        chk({cap_done, cap_flags}, {1'b0, exp_flags(16'h8206)});
        chk(ext_seg_ready, 1'b1);
        repeat (3) i_par.send_seg();
        apb(1'b0, 12'h014, 32'h0);
        chk(rd, 32'h00000003);
        apb(1'b1, 12'h000, 32'h00000001);
        $display("t_seg done");
    endtask
    task finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #100000;
        bad_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        finish_test();
    end
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_caps();
        t_support();
        t_comp();
        t_seg();
        finish_test();
    end
endmodule // capability_header_decoder_tb
`default_nettype wire
